// ===== blc_backlight_ctrl.sv
// Functional notes
// R1: Brightness from PWM input unless bus-selected
// R2: Faults clear by bus or enable fall
// R3: Optional twelve-bit per-channel current scale
// R4: Phase step is 360/N per string
// R5: Unused outputs off, no faults, no boost
// R6: Faults shown on open-drain interrupt pin
// R7: Detect external sync clock at start-up
// R8: Sync strap high enables spread spectrum
// R9: Enable gates bus writes and fault detection
// R10: Charge pump on unless supply pins tied
// R11: Fly cap flag; pump fault raises interrupt
// R12: Pump fault interrupt masked by enable bit
// R13: Boost frequency picked from strap step
// R14: Interrupt low while enabled fault set
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "blc_defs.svh"
module blc_backlight_ctrl (
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [7:0]            haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	input  wire logic                  enable_pin,
	input  wire logic                  pwm_pin,
	input  wire logic                  boost_clock_sync_input,
	input  wire logic                  supply_tied_to_pump,
	input  wire logic                  fly_cap_sense,
	input  wire logic                  pump_fault_in,
	input  wire logic                  boost_fault_in,
	input  wire logic [5:0]            led_fault_in,
	input  wire logic [2:0]            string_count_strap,
	input  wire logic [2:0]            boost_freq_strap,
	output logic                       int_n_oe,
	output logic                       int_n_out,
	output logic                       pump_on,
	output logic                       spread_on,
	output logic                       ext_clk_sel,
	output logic      [2:0]            boost_freq_sel,
	output logic      [5:0]            out_enable,
	output logic      [5:0]            boost_loop_mask,
	output logic      [8:0]            phase_step_deg,
	output logic                       bright_pwm,
	output logic                       bright_from_bus,
	output logic      [71:0]           channel_current_scale
);
	import blc_pkg::*;

	// Synchronisers for all outside pins
	logic [1:0] en_sy_ff, pwm_sy_ff, syn_sy_ff, pf_sy_ff, bf_sy_ff;
	logic [1:0] tie_sy_ff, cap_sy_ff;
	logic [5:0] lf1_ff, lf2_ff;
	logic [2:0] cnt1_ff, cnt2_ff;        // String count strap sync
	logic [2:0] frq1_ff, frq2_ff;        // Boost step strap sync
	logic       en_d_ff;                 // Previous synced enable
	logic       syn_d_ff;                // Previous synced sync input
	blc_state_t state_ff;                // Start-up phase
	logic [15:0] win_ff;                 // Detection window count
	logic        edge_seen_ff;           // Sync edge during window
	logic [2:0]  n_ff;                   // Captured string count
	logic [2:0]  st_ff;                  // Sticky fault status
	logic [2:0]  ien_ff;                 // Interrupt enables
	logic [1:0]  ctrl_ff;                // Control bits
	logic [15:0] bright_ff;              // Bus brightness
	logic [11:0] cur_ff [`BLC_NUM_CH];   // Per-channel scale
	logic        wr_pend_ff;             // Write data phase due
	logic [7:0]  wr_addr_ff;             // Latched write address
	logic [5:0]  used;                   // Outputs in use
	logic [2:0]  ev;                     // Fault events this cycle
	logic        en_s, en_fall, run;
	logic        rd_req;

	assign en_s    = en_sy_ff[1];
	assign en_fall = en_d_ff & ~en_s;
	assign run     = en_s && (state_ff == BLC_ST_RUN);
	assign rd_req  = hsel && hready && htrans[1] && !hwrite;

	// Two-flop synchronisers; only stage two is read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_sy_ff  <= 2'h0;
			pwm_sy_ff <= 2'h0;
			syn_sy_ff <= 2'h0;
			pf_sy_ff  <= 2'h0;
			bf_sy_ff  <= 2'h0;
			tie_sy_ff <= 2'h0;
			cap_sy_ff <= 2'h0;
			lf1_ff    <= 6'h00;
			lf2_ff    <= 6'h00;
			cnt1_ff   <= 3'h0;
			cnt2_ff   <= 3'h0;
			frq1_ff   <= 3'h0;
			frq2_ff   <= 3'h0;
			en_d_ff   <= 1'b0;
			syn_d_ff  <= 1'b0;
		end else begin
			en_sy_ff  <= {en_sy_ff[0], enable_pin};
			pwm_sy_ff <= {pwm_sy_ff[0], pwm_pin};
			syn_sy_ff <= {syn_sy_ff[0], boost_clock_sync_input};
			pf_sy_ff  <= {pf_sy_ff[0], pump_fault_in};
			bf_sy_ff  <= {bf_sy_ff[0], boost_fault_in};
			tie_sy_ff <= {tie_sy_ff[0], supply_tied_to_pump};
			cap_sy_ff <= {cap_sy_ff[0], fly_cap_sense};
			lf1_ff    <= led_fault_in;
			lf2_ff    <= lf1_ff;
			// Straps are static but still async to hclk
			cnt1_ff   <= string_count_strap;
			cnt2_ff   <= cnt1_ff;
			frq1_ff   <= boost_freq_strap;
			frq2_ff   <= frq1_ff;
			en_d_ff   <= en_s;
			syn_d_ff  <= syn_sy_ff[1];
		end
	end

	// Start-up: catch straps, then watch sync input for edges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff       <= BLC_ST_OFF;
			win_ff         <= 16'h0000;
			edge_seen_ff   <= 1'b0;
			n_ff           <= 3'h0;
			ext_clk_sel    <= 1'b0;
			spread_on      <= 1'b0;
			boost_freq_sel <= 3'h0;
			pump_on        <= 1'b0;
		end else if (!en_s) begin
			state_ff     <= BLC_ST_OFF; // R9
			edge_seen_ff <= 1'b0;
		end else begin
			unique case (state_ff)
			BLC_ST_OFF: begin
				// Straps are static while enabled, so sample once
				n_ff           <= cnt2_ff;
				boost_freq_sel <= frq2_ff; // R13
				pump_on        <= ~tie_sy_ff[1]; // R10
				win_ff         <= `BLC_SYNC_WIN;
				state_ff       <= BLC_ST_DETECT;
			end
			BLC_ST_DETECT: begin
				if (syn_sy_ff[1] != syn_d_ff)
					edge_seen_ff <= 1'b1;
				if (win_ff == 16'h0001) begin
					// Edges mean a clock; otherwise a steady level strap
					ext_clk_sel <= edge_seen_ff; // R7
					spread_on   <= !edge_seen_ff && syn_sy_ff[1]; // R8
					state_ff    <= BLC_ST_RUN;
				end
				win_ff <= win_ff - 16'h0001;
			end
			BLC_ST_RUN: begin
				state_ff <= BLC_ST_RUN;
			end
			endcase
		end
	end

	// Used outputs from count; 0 or above six means all six
	always_comb begin
		unique case (n_ff)
		3'h1: used = 6'h01;
		3'h2: used = 6'h03;
		3'h3: used = 6'h07;
		3'h4: used = 6'h0F;
		3'h5: used = 6'h1F;
		default: used = 6'h3F;
		endcase
	end

	// Per-output enable, boost loop mask and phase spacing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_enable      <= 6'h00;
			boost_loop_mask <= 6'h00;
			phase_step_deg  <= 9'h000;
		end else begin
			out_enable      <= run ? used : 6'h00; // R5
			boost_loop_mask <= run ? used : 6'h00; // R5
			unique case (used)
			6'h01: phase_step_deg <= 9'd360; // R4
			6'h03: phase_step_deg <= 9'd180;
			6'h07: phase_step_deg <= 9'd120;
			6'h0F: phase_step_deg <= 9'd90;
			6'h1F: phase_step_deg <= 9'd72;
			default: phase_step_deg <= 9'd60;
			endcase
		end
	end

	// Events only while running; unused outputs never report
	assign ev[`BLC_ST_PUMP_FAULT]  = run && pump_on && pf_sy_ff[1]; // R11
	assign ev[`BLC_ST_LED_FAULT]   = run && |(lf2_ff & used); // R5
	assign ev[`BLC_ST_BOOST_FAULT] = run && bf_sy_ff[1];

	// AHB write data phase marker
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end else if (hready) begin
			// Bus writes ignored while disabled
			wr_pend_ff <= en_s && hsel && htrans[1] && hwrite; // R9
			wr_addr_ff <= haddr;
		end
	end

	// Control and enable registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff   <= 2'h0;
			bright_ff <= 16'h0000;
			ien_ff    <= `BLC_IRQ_EN_RST;
		end else if (wr_pend_ff) begin
			if (wr_addr_ff == `BLC_ADDR_CTRL) begin
				ctrl_ff   <= hwdata[1:0]; // R1
				bright_ff <= hwdata[31:16];
			end
			if (wr_addr_ff == `BLC_ADDR_IRQ_EN)
				ien_ff <= hwdata[2:0]; // R12
		end
	end

	// Channel current scale registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < `BLC_NUM_CH; i++)
				cur_ff[i] <= `BLC_CUR_RST;
		end else begin
			for (int i = 0; i < `BLC_NUM_CH; i++)
				if (wr_pend_ff &&
				    wr_addr_ff == `BLC_ADDR_CUR_BASE + 8'(4 * i))
					cur_ff[i] <= hwdata[11:0]; // R3
		end
	end

	// Sticky status; set wins over bus clear, enable fall clears
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= 3'h0;
		end else if (en_fall) begin
			st_ff <= 3'h0; // R2
		end else if (wr_pend_ff && wr_addr_ff == `BLC_ADDR_IRQ_CLR) begin
			st_ff <= (st_ff & ~hwdata[2:0]) | ev; // R2
		end else begin
			st_ff <= st_ff | ev;
		end
	end

	// Open-drain interrupt: drive low while enabled fault held
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_n_oe  <= 1'b0;
			int_n_out <= 1'b0;
		end else begin
			int_n_oe  <= |(st_ff & ien_ff); // R6 R12 R14
			int_n_out <= 1'b0;
		end
	end

	// Brightness source select and scale outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bright_pwm            <= 1'b0;
			bright_from_bus       <= 1'b0;
			channel_current_scale <= 72'h0;
		end else begin
			bright_from_bus <= ctrl_ff[`BLC_CTRL_BUS_BRIGHT]; // R1
			bright_pwm <= run && (ctrl_ff[`BLC_CTRL_BUS_BRIGHT] ?
			              (bright_ff != 16'h0000) : pwm_sy_ff[1]); // R1
			for (int i = 0; i < `BLC_NUM_CH; i++)
				channel_current_scale[12*i +: 12] <=
				    ctrl_ff[`BLC_CTRL_SCALE_EN] ? cur_ff[i]
				                                : `BLC_CUR_RST; // R3
		end
	end

	// AHB read data, zero wait, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (rd_req) begin
			hrdata <= 32'h0000_0000;
			if (haddr == `BLC_ADDR_CTRL)
				hrdata <= {bright_ff, 14'h0, ctrl_ff};
			else if (haddr == `BLC_ADDR_STATUS)
				hrdata <= {27'h0, cap_sy_ff[1] & pump_on, // R11
				           pump_on, st_ff};
			else if (haddr == `BLC_ADDR_IRQ_EN)
				hrdata <= {29'h0, ien_ff};
			else if (haddr == `BLC_ADDR_INFO)
				hrdata <= {24'h0, spread_on, ext_clk_sel,
				           n_ff, boost_freq_sel};
			for (int i = 0; i < `BLC_NUM_CH; i++)
				if (haddr == `BLC_ADDR_CUR_BASE + 8'(4 * i))
					hrdata <= {20'h0, cur_ff[i]};
		end
	end
endmodule
`default_nettype wire

// ===== blc_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module blc_ctrl_sva (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       enable_pin,
	input wire logic       pwm_pin,
	input wire logic       int_n_oe,
	input wire logic       int_n_out,
	input wire logic       spread_on,
	input wire logic       ext_clk_sel,
	input wire logic [5:0] out_enable,
	input wire logic [5:0] boost_loop_mask,
	input wire logic [8:0] phase_step_deg,
	input wire logic       bright_pwm,
	input wire logic       bright_from_bus
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_bus; hreadyout && !hresp; endproperty
	property p_od; int_n_oe |-> int_n_out == 1'b0; endproperty
	property p_step;
		out_enable != 6'h00 |-> phase_step_deg * $countones(out_enable) == 360;
	endproperty
	property p_mask; boost_loop_mask == out_enable; endproperty
	// Six cycles covers the two sync flops plus the clear
	property p_off;
		!enable_pin [*6] |-> out_enable == 6'h00 && !int_n_oe;
	endproperty
	property p_pwm;
		(!bright_from_bus && out_enable != 6'h00 && pwm_pin) [*5] |-> bright_pwm;
	endproperty
	property p_spread; spread_on |-> !ext_clk_sel; endproperty
	property p_clr; $fell(enable_pin) |-> ##[1:8] !int_n_oe; endproperty
	a_bus: assert property (p_bus) else $error("bus stall or error");
	a_od: assert property (p_od) else $error("pin driven high");
	a_step: assert property (p_step) else $error("phase step wrong");
	a_mask: assert property (p_mask) else $error("loop mask wrong");
	a_off: assert property (p_off) else $error("active while off");
	a_pwm: assert property (p_pwm) else $error("pwm not followed");
	a_spread: assert property (p_spread) else $error("spread on ext");
	a_clr: assert property (p_clr) else $error("irq not cleared");
	c_ext: cover property (ext_clk_sel);
	c_irq: cover property ($fell(int_n_oe));
	c_bus: cover property (bright_from_bus && bright_pwm);
endmodule
bind blc_backlight_ctrl blc_ctrl_sva chk_u (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .enable_pin(enable_pin),
	.pwm_pin(pwm_pin), .int_n_oe(int_n_oe), .int_n_out(int_n_out),
	.spread_on(spread_on), .ext_clk_sel(ext_clk_sel), .out_enable(out_enable),
	.boost_loop_mask(boost_loop_mask), .phase_step_deg(phase_step_deg),
	.bright_pwm(bright_pwm), .bright_from_bus(bright_from_bus));
`default_nettype wire

// ===== blc_defs.svh
`ifndef BLC_DEFS_SVH
`define BLC_DEFS_SVH

// Register byte addresses
`define BLC_ADDR_CTRL      8'h00
`define BLC_ADDR_STATUS    8'h04
`define BLC_ADDR_IRQ_EN    8'h08
`define BLC_ADDR_IRQ_CLR   8'h0C
`define BLC_ADDR_INFO      8'h10
`define BLC_ADDR_CUR_BASE  8'h20

// Control fields
`define BLC_CTRL_BUS_BRIGHT 0
`define BLC_CTRL_SCALE_EN   1
`define BLC_CTRL_BRIGHT_LSB 16

// Status bit positions
`define BLC_ST_PUMP_FAULT   0
`define BLC_ST_LED_FAULT    1
`define BLC_ST_BOOST_FAULT  2
`define BLC_NUM_ST          3

// Reset values
`define BLC_IRQ_EN_RST      3'h7
`define BLC_CUR_RST         12'hFFF

// Sync detection window in hclk cycles
`define BLC_SYNC_WIN        16'h0400
`define BLC_NUM_CH          6

`endif

// ===== blc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module blc_host_model (
	input  wire logic en_req,
	input  wire logic pwm_req,
	input  wire logic clk_req,
	input  wire logic lvl_req,
	output logic      enable_pin,
	output logic      pwm_pin,
	output logic      boost_clock_sync_input
);
	logic sync_clk; // 64 ns source, unrelated to hclk
	initial begin
		sync_clk = 1'b0;
		forever #32 sync_clk = ~sync_clk;
	end
	// Enable falls are the host's way to clear faults
	assign enable_pin = en_req;
	assign pwm_pin = pwm_req;
	// Clock only inside start-up frames, else a static strap
	assign boost_clock_sync_input = clk_req ? sync_clk : lvl_req;
endmodule
`default_nettype wire

// ===== blc_pkg.sv
package blc_pkg;
	// Clock source of the boost
	typedef enum logic {
		BLC_CLK_INTERNAL,
		BLC_CLK_EXTERNAL
	} blc_clk_src_t;
	// Start-up detection phases
	typedef enum logic [1:0] {
		BLC_ST_OFF,
		BLC_ST_DETECT,
		BLC_ST_RUN
	} blc_state_t;
endpackage

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "blc_defs.svh"
`define CHK(nm,ex,got) begin \
	checked++; \
	if ((got) !== (ex)) begin \
		n_mismatch++; \
		$display("unexpected %s exp %h got %h", nm, ex, got); \
	end \
end
module testbench;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [31:0] hwdata, hrdata, rd;
	logic        en_req, pwm_req, clk_req, lvl_req, enable_pin, pwm_pin, sync_in;
	logic        tie_pump, pump_flt, int_n_oe, pump_on, spread_on, ext_clk_sel;
	logic [2:0]  n_strap, boost_freq_sel;
	logic [5:0]  led_flt, out_enable;
	logic [8:0]  phase_step_deg;
	logic        bright_pwm, bright_from_bus;
	logic [71:0] scale;
	int          n_mismatch, checked, cyc;
	blc_host_model host_u (.en_req(en_req), .pwm_req(pwm_req),
		.clk_req(clk_req), .lvl_req(lvl_req), .enable_pin(enable_pin),
		.pwm_pin(pwm_pin), .boost_clock_sync_input(sync_in));
	blc_backlight_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .enable_pin(enable_pin),
		.pwm_pin(pwm_pin), .boost_clock_sync_input(sync_in),
		.supply_tied_to_pump(tie_pump), .fly_cap_sense(lvl_req),
		.pump_fault_in(pump_flt), .boost_fault_in(1'b0), .led_fault_in(led_flt),
		.string_count_strap(n_strap), .boost_freq_strap(n_strap),
		.int_n_oe(int_n_oe), .int_n_out(), .pump_on(pump_on),
		.spread_on(spread_on), .ext_clk_sel(ext_clk_sel),
		.boost_freq_sel(boost_freq_sel), .out_enable(out_enable),
		.boost_loop_mask(), .phase_step_deg(phase_step_deg),
		.bright_pwm(bright_pwm), .bright_from_bus(bright_from_bus),
		.channel_current_scale(scale));
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	task automatic give_verdict;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Hang guard: whole run needs about 6450 cycles
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict;
		end
	end
	// One single transfer; read data lands in rd
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		hsel <= 1'b0;
	endtask
	// Start-up with n strings; output 5 reports a fault, unused unless n is 6
	task automatic t_start(input int n);
		logic ext;
		ext = (n == 3);
		en_req <= 1'b0;
		repeat (8) @(posedge hclk);
		n_strap <= 3'(n);
		tie_pump <= (n < 4);
		lvl_req <= n[0];
		clk_req <= ext;
		led_flt <= 6'h20;
		en_req <= 1'b1;
		repeat (1045) @(posedge hclk);
		clk_req <= 1'b0;
		`CHK("out_enable", 6'h3f >> (6 - n), out_enable)
		`CHK("phase", 9'(360 / n), phase_step_deg)
		`CHK("ext_clk", ext, ext_clk_sel)
		`CHK("spread", !ext && n[0], spread_on)
		`CHK("pump_on", n >= 4, pump_on)
		`CHK("freq", 3'(n), boost_freq_sel)
		ahb(1'b0, `BLC_ADDR_STATUS, 32'h0000_0000);
		`CHK("led_fault", n == 6, rd[1])
		`CHK("irq", n == 6, int_n_oe)
		`CHK("fly_cap", n >= 4 && n[0], rd[4])
		ahb(1'b0, `BLC_ADDR_INFO, 32'h0000_0000);
		`CHK("info", {24'h0, !ext && n[0], ext, 3'(n), 3'(n)}, rd)
		led_flt <= 6'h00;
	endtask
	// Scale enable, current scale, bus and pwm brightness, unmapped read
	task automatic t_bus;
		ahb(1'b1, `BLC_ADDR_CTRL, 32'h0001_0003);
		ahb(1'b1, `BLC_ADDR_CUR_BASE + 8'h08, 32'h0000_0123);
		repeat (2) @(posedge hclk);
		`CHK("scale2", 12'h123, scale[35:24])
		`CHK("scale0", 12'hfff, scale[11:0])
		`CHK("from_bus", 1'b1, bright_from_bus)
		`CHK("bus_on", 1'b1, bright_pwm)
		ahb(1'b0, `BLC_ADDR_CUR_BASE + 8'h08, 32'h0000_0000);
		`CHK("cur2_rd", 32'h0000_0123, rd)
		ahb(1'b1, `BLC_ADDR_CTRL, 32'h0000_0000);
		pwm_req <= 1'b1;
		repeat (6) @(posedge hclk);
		`CHK("pwm_hi", 1'b1, bright_pwm)
		`CHK("scale_off", 12'hfff, scale[35:24])
		pwm_req <= 1'b0;
		repeat (6) @(posedge hclk);
		`CHK("pwm_lo", 1'b0, bright_pwm)
		ahb(1'b0, 8'h40, 32'h0000_0000);
		`CHK("unmapped", 32'h0000_0000, rd)
	endtask
	// Bus clear of start-up fault, then pump fault: raise, mask, sticky, clear by enable fall
	task automatic t_irq;
		ahb(1'b1, `BLC_ADDR_IRQ_CLR, 32'h0000_0007);
		repeat (4) @(posedge hclk);
		`CHK("bus_clear", 1'b0, int_n_oe)
		pump_flt <= 1'b1;
		repeat (8) @(posedge hclk);
		`CHK("pump_irq", 1'b1, int_n_oe)
		ahb(1'b0, `BLC_ADDR_STATUS, 32'h0000_0000);
		`CHK("pump_flag", 1'b1, rd[0])
		ahb(1'b1, `BLC_ADDR_IRQ_EN, 32'h0000_0006);
		repeat (3) @(posedge hclk);
		`CHK("masked", 1'b0, int_n_oe)
		ahb(1'b1, `BLC_ADDR_IRQ_EN, 32'h0000_0007);
		pump_flt <= 1'b0;
		repeat (8) @(posedge hclk);
		`CHK("sticky", 1'b1, int_n_oe)
		en_req <= 1'b0;
		repeat (8) @(posedge hclk);
		`CHK("en_clear", 1'b0, int_n_oe)
		`CHK("off", 6'h00, out_enable)
		ahb(1'b1, `BLC_ADDR_CTRL, 32'h0000_0001);
		ahb(1'b0, `BLC_ADDR_CTRL, 32'h0000_0000);
		`CHK("dropped", 32'h0000_0000, rd)
	endtask
	initial begin
		{hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
		{en_req, pwm_req, clk_req, lvl_req, tie_pump, pump_flt} = '0;
		{n_strap, led_flt} = '0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		for (int n = 1; n <= 6; n++) begin
			t_start(n);
		end
		t_bus;
		t_irq;
		give_verdict;
	end
endmodule
`default_nettype wire
